// ===== src/adc_host_ctrl.sv
/*
  host controller for a clockless 8-bit half-flash converter: drives select,
  read, write and mode strobes, collects result and over-range, and reports
  through apb registers with a masked level interrupt.
  assumes pins are synchronous to i_clk (50 MHz) and that the converter
  obeys its own timing.
*/
`timescale 1ns/1ps
`include "adc_host_regs.svh"

module adc_host_ctrl
  import adc_host_pkg::*;
#(
  parameter int CLK_NS = `T_CLK_NS
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // converter pins
  output logic o_sel_n,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic o_wr_oe_n,
  output logic o_mode,
  input wire logic i_wr_rdy,
  input wire logic i_done_n,
  input wire logic [7:0] i_result_lines,
  input wire logic i_overrange_flag_n,
  // interrupt
  output logic o_irq
);

  localparam int N_PREP = (`T_PREP_NS + CLK_NS - 1) / CLK_NS;
  localparam int N_WR = (`T_WR_NS + CLK_NS - 1) / CLK_NS;
  localparam int N_GAP = (`T_WR_RD_NS + CLK_NS - 1) / CLK_NS;
  localparam int N_READ = (`T_READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int N_WAIT = `T_WAIT_NS / CLK_NS;

  ////////////////////////////////////////////////////////////////////////
  host_state_t st_r, st_nxt;
  strobe_t pin_r, pin_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [7:0] result_r, result_nxt;
  logic ovr_r, ovr_nxt;
  logic mode_r, mode_nxt;
  logic fast_r, fast_nxt;
  logic [`IRQ_W-1:0] istat_r, istat_nxt, imask_r, imask_nxt;
  logic [31:0] prdata_nxt;
  logic pready_r, pready_nxt, pslverr_nxt;
  logic wr_acc, rd_acc, start, ev_done;
  logic [`IRQ_W-1:0] ev;

  // apb access phase; ready answers one cycle after the access starts
  assign wr_acc = i_psel & i_penable & i_pwrite & ~pready_r;
  assign rd_acc = i_psel & i_penable & ~i_pwrite & ~pready_r;
  assign start = wr_acc & (i_paddr == `REG_CTRL) & i_pwdata[`CTRL_START]
    & (st_r == ST_IDLE);

  // sequencer next state
  always_comb begin
    st_nxt = st_r;
    pin_nxt = pin_r;
    cnt_nxt = (cnt_r != 6'h00) ? cnt_r - 6'h01 : cnt_r;
    result_nxt = result_r;
    ovr_nxt = ovr_r;
    ev_done = 1'b0;
    case (st_r)
      ST_IDLE: begin
        pin_nxt.mode = mode_r;
        // write pin released in single-read mode
        pin_nxt.wr_oe_n = ~mode_r;
        if (start) begin
          st_nxt = ST_PREP;
          cnt_nxt = 6'(N_PREP);
        end
      end
      ST_PREP: begin
        if (cnt_r == 6'h00) begin
          pin_nxt.sel_n = 1'b0;
          if (pin_r.mode) begin
            pin_nxt.wr_n = 1'b0;
            st_nxt = ST_WR;
            cnt_nxt = 6'(N_WR);
          end else begin
            // one long read in single-read mode
            pin_nxt.rd_n = 1'b0;
            st_nxt = ST_WAIT;
            cnt_nxt = 6'(N_WAIT);
          end
        end
      end
      ST_WR: begin
        if (cnt_r == 6'h00) begin
          pin_nxt.wr_n = 1'b1;
          // write-to-read spacing is kept even if completion comes early
          st_nxt = ST_GAP;
          cnt_nxt = 6'(N_GAP);
        end
      end
      ST_GAP: begin
        if (cnt_r == 6'h00) begin
          if (fast_r) begin
            pin_nxt.rd_n = 1'b0;
            st_nxt = ST_RD;
            cnt_nxt = 6'(N_READ);
          end else begin
            st_nxt = ST_WAIT;
            cnt_nxt = 6'(N_WAIT);
          end
        end
      end
      ST_WAIT: begin
        if (!i_done_n || cnt_r == 6'h00) begin
          pin_nxt.rd_n = 1'b0;
          st_nxt = ST_RD;
          cnt_nxt = 6'(N_READ);
        end
      end
      ST_RD: begin
        if (cnt_r == 6'h00) begin
          result_nxt = i_result_lines;
          ovr_nxt = ~i_overrange_flag_n;
          pin_nxt.rd_n = 1'b1;
          pin_nxt.sel_n = 1'b1;
          st_nxt = ST_REL;
        end
      end
      ST_REL: begin
        ev_done = 1'b1;
        st_nxt = ST_IDLE;
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= ST_IDLE;
      pin_r <= '{sel_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, wr_oe_n: 1'b1,
        mode: 1'b0};
      cnt_r <= 6'h00;
      result_r <= 8'h00;
      ovr_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      pin_r <= pin_nxt;
      cnt_r <= cnt_nxt;
      result_r <= result_nxt;
      ovr_r <= ovr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register file next values; set beats write-one-clear
  always_comb begin
    ev = '0;
    ev[`IRQ_DONE] = ev_done;
    ev[`IRQ_OVR] = ev_done & ovr_nxt;
    mode_nxt = mode_r;
    fast_nxt = fast_r;
    imask_nxt = imask_r;
    istat_nxt = istat_r;
    prdata_nxt = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    pready_nxt = i_psel & i_penable & ~pready_r;
    if (wr_acc) begin
      case (i_paddr)
        `REG_CTRL: begin
          mode_nxt = i_pwdata[`CTRL_MODE];
          fast_nxt = i_pwdata[`CTRL_FAST];
        end
        `REG_IRQ_STAT: istat_nxt = istat_r & ~i_pwdata[`IRQ_W-1:0];
        `REG_IRQ_MASK: imask_nxt = i_pwdata[`IRQ_W-1:0];
        `REG_STATUS, `REG_RESULT: pslverr_nxt = 1'b0;
        default: pslverr_nxt = 1'b1;
      endcase
    end
    if (rd_acc) begin
      case (i_paddr)
        `REG_CTRL: begin
          prdata_nxt[`CTRL_MODE] = mode_r;
          prdata_nxt[`CTRL_FAST] = fast_r;
        end
        `REG_STATUS: begin
          prdata_nxt[`STAT_BUSY] = (st_r != ST_IDLE);
          prdata_nxt[`STAT_RDY] = i_wr_rdy;
        end
        `REG_IRQ_STAT: prdata_nxt[`IRQ_W-1:0] = istat_r;
        `REG_IRQ_MASK: prdata_nxt[`IRQ_W-1:0] = imask_r;
        `REG_RESULT: prdata_nxt[8:0] = {ovr_r, result_r};
        default: pslverr_nxt = 1'b1;
      endcase
    end
    istat_nxt = istat_nxt | ev;
  end

  // register file and bus outputs
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_r <= 1'b0;
      fast_r <= 1'b0;
      imask_r <= '0;
      istat_r <= '0;
      o_prdata <= 32'h0000_0000;
      pready_r <= 1'b0;
      o_pslverr <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      fast_r <= fast_nxt;
      imask_r <= imask_nxt;
      istat_r <= istat_nxt;
      o_prdata <= prdata_nxt;
      pready_r <= pready_nxt;
      o_pslverr <= pslverr_nxt;
      o_irq <= |(istat_nxt & imask_nxt);
    end
  end

  // pins straight from flops
  assign o_pready = pready_r;
  assign o_sel_n = pin_r.sel_n;
  assign o_rd_n = pin_r.rd_n;
  assign o_wr_n = pin_r.wr_n;
  assign o_wr_oe_n = pin_r.wr_oe_n;
  assign o_mode = pin_r.mode;

endmodule

// ===== src/adc_host_pkg.sv
/*
  types for the converter host controller.
  assumes the regs header is compiled alongside.
*/
package adc_host_pkg;
  // controller states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PREP = 3'b001,
    ST_WR = 3'b010,
    ST_GAP = 3'b011,
    ST_WAIT = 3'b100,
    ST_RD = 3'b101,
    ST_REL = 3'b110
  } host_state_t;

  // strobes toward the converter
  typedef struct packed {
    logic sel_n;
    logic rd_n;
    logic wr_n;
    logic wr_oe_n;
    logic mode;
  } strobe_t;
endpackage

// ===== src/adc_host_regs.svh
/*
  register offsets, field positions and timing figures for the converter
  host controller. assumes it is included by its bare name.
*/
`ifndef ADC_HOST_REGS_SVH
`define ADC_HOST_REGS_SVH

// apb register byte offsets
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_IRQ_STAT 12'h008
`define REG_IRQ_MASK 12'h00c
`define REG_RESULT 12'h010

// ctrl fields
`define CTRL_START 0
`define CTRL_MODE 1
`define CTRL_FAST 2
// status fields
`define STAT_BUSY 0
`define STAT_RDY 1
// irq fields
`define IRQ_DONE 0
`define IRQ_OVR 1
`define IRQ_W 2

// converter timing in ns
`define T_CLK_NS 20
`define T_PREP_NS 350
`define T_WR_NS 250
`define T_WR_RD_NS 250
`define T_READ_NS 240
`define T_WAIT_NS 1000

`endif

// ===== test/adc_dev_model.sv
/* converter model: strobes in, result and flags out.
   assumes strobes change just after clock edges. */
`timescale 1ns/1ps
module adc_dev_model (
  // strobes
  input wire logic i_sel_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic i_wr_oe_n,
  input wire logic i_mode,
  // stimulus: over bit and code, latency in ns
  input wire logic [8:0] i_code,
  input wire logic [31:0] i_lat,
  // pins
  output logic o_wr_rdy,
  output logic o_done_n,
  output logic o_ovr_n,
  output logic [7:0] o_res
);
  logic [8:0] smp = 0, outv = 0;
  logic busy = 0;
  wire m = (i_mode === 1'b1);
  initial o_done_n = 1;
  // sample on write fall
  // select and strobe may fall in one step; look a moment later
  always @(negedge i_wr_n) begin
    #1;
    if (!i_sel_n && m) begin
      smp = i_code;
      busy = 1;
    end
  end
  // read fall starts or ends it
  always @(negedge i_rd_n) begin
    #1;
    if (i_sel_n) begin
    end else if (m) begin
      outv = smp;
      busy = 0;
    end else begin
      smp = i_code;
      busy = 1;
      #(i_lat) outv = smp;
      busy = 0;
      o_done_n = 0;
    end
  end
  always @(posedge i_wr_n) if (!i_sel_n && m) begin
    #(i_lat) if (busy) begin
      outv = smp;
      busy = 0;
      o_done_n = 0;
    end
  end
  // select or read rise clears it
  always @(posedge i_rd_n or posedge i_sel_n) o_done_n = 1;
  assign o_res = (!i_sel_n && !i_rd_n) ? outv[7:0] : ~outv[7:0];
  assign o_ovr_n = !outv[8];
  // shared pin: host write or ready
  assign o_wr_rdy = i_wr_oe_n ? !busy : i_wr_n;
endmodule

// ===== test/adc_host_ctrl_assertions.sv
/* pin checker for adc_host_ctrl.
   assumes it is bound to every instance of that module. */
`timescale 1ns/1ps
module adc_host_chk (
  // clock, reset, bus
  input logic i_clk,
  input logic i_arst_n,
  input logic i_psel,
  input logic i_penable,
  input logic o_pready,
  // converter pins
  input logic o_sel_n,
  input logic o_rd_n,
  input logic o_wr_n,
  input logic o_wr_oe_n,
  input logic o_mode
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // strobe widths in cycles
  sequence wr_pulse;
    (!o_wr_n)[*8] ##1 (!o_wr_n)[*6] ##1 o_wr_n;
  endsequence
  sequence rd_pulse;
    (!o_rd_n)[*8] ##1 (!o_rd_n)[*5] ##1 o_rd_n;
  endsequence
  a_rd_sel: assert property (!o_rd_n |-> !o_sel_n)
    else $error("read without select");
  a_wr_sel: assert property (!o_wr_n |-> !o_sel_n && o_mode)
    else $error("write without select");
  a_pin_dir: assert property (o_wr_oe_n == !o_mode)
    else $error("shared pin direction");
  a_wr_width: assert property ($fell(o_wr_n) |-> wr_pulse)
    else $error("write width");
  a_rd_width: assert property ($fell(o_rd_n) && o_mode |-> rd_pulse)
    else $error("read width");
  a_rd_long: assert property ($fell(o_rd_n) |-> (!o_rd_n)[*8])
    else $error("read too short");
  a_wr_rd_gap: assert property ($rose(o_wr_n) |-> o_rd_n[*8])
    else $error("read too early");
  a_mode_hold: assert property (!o_sel_n |=> $stable(o_mode))
    else $error("mode moved");
  a_prep_gap: assert property ($rose(o_sel_n) |-> o_sel_n[*8])
    else $error("prep gap");
  a_apb_answer: assert property (i_psel && i_penable && !o_pready
    |=> o_pready ##1 !o_pready) else $error("bus answer");
endmodule
bind adc_host_ctrl adc_host_chk u_chk (.*);

// ===== test/tb_adc_host_ctrl.sv
/* bench for adc_host_ctrl driving a converter model over apb.
   assumes package, header, checker and model compile first. */
`timescale 1ns/1ps
`include "adc_host_regs.svh"
module tb_adc_host_ctrl;
  logic i_clk = 0, i_arst_n = 0, psel = 0, pen = 0, pwr = 0, e, m, f;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, prd, r;
  logic prdy, perr, sel_n, rd_n, wr_n, oe_n, mode, rdy, done_n, ovr_n, irq;
  logic [7:0] res;
  logic [8:0] code = 0, q[$];
  logic [1:0] msk;
  int lat = 200, bad_count = 0, num_checks = 0, n;
  always #10 i_clk = ~i_clk;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("Error at %0t: got %h want %h", $time, a, b); end end
  adc_host_ctrl DUT (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
    .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr), .o_sel_n(sel_n),
    .o_rd_n(rd_n), .o_wr_n(wr_n), .o_wr_oe_n(oe_n), .o_mode(mode),
    .i_wr_rdy(rdy), .i_done_n(done_n), .i_result_lines(res),
    .i_overrange_flag_n(ovr_n), .o_irq(irq));
  adc_dev_model dev (.i_sel_n(sel_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
    .i_wr_oe_n(oe_n), .i_mode(mode), .i_code(code), .i_lat(lat),
    .o_wr_rdy(rdy), .o_done_n(done_n), .o_ovr_n(ovr_n), .o_res(res));
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one apb transfer, held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge i_clk);
    pen <= 1;
    n = 0;
    do begin @(posedge i_clk); n++; end while (prdy !== 1 && n < 20);
    r = prd;
    e = perr;
    psel <= 0;
    pen <= 0;
    if (n >= 20) begin bad_count++; give_verdict; end
  endtask
  initial begin
    void'($urandom(32'hdfc40bb0));
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1;
    `CHK({sel_n, rd_n, wr_n, oe_n, mode, irq}, 6'b111100)
    apb(0, 12'h020, 32'h0);
    `CHK(e, 1'b1)
    // mode and speed from the loop index; random mask, code and converter latency
    for (int i = 0; i < 8; i++) begin
      m = 1'(i);
      f = 1'(i >> 1);
      msk = 2'($urandom);
      code = 9'($urandom);
      lat = 100 + int'($urandom % 500);
      q.push_back(code);
      apb(1, `REG_IRQ_MASK, 32'(msk));
      apb(1, `REG_CTRL, 32'({f, m, 1'b0}));
      apb(1, `REG_CTRL, 32'({f, m, 1'b1}));
      `CHK(mode, m)
      `CHK(oe_n, !m)
      apb(0, `REG_STATUS, 32'h0);
      `CHK(r[0], 1'b1)
      for (int k = 0; r[0] && k < 60; k++) apb(0, `REG_STATUS, 32'h0);
      if (r[0] !== 1'b0) begin bad_count++; give_verdict; end
      `CHK(r[1], 1'b1)
      apb(0, `REG_RESULT, 32'h0);
      `CHK(r[8:0], q.pop_front())
      apb(0, `REG_IRQ_STAT, 32'h0);
      `CHK(r[1:0], {code[8], 1'b1})
      `CHK(irq, |({code[8], 1'b1} & msk))
      apb(1, `REG_IRQ_STAT, 32'h3);
      apb(0, `REG_IRQ_STAT, 32'h0);
      `CHK({r[1:0], irq}, 3'b000)
    end
    give_verdict;
  end
endmodule
